// File: hdl/io_boundary_pkg.sv
package io_boundary_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int LANES = 6;
  localparam int LANE_W = 8;
  localparam int TAP_W = 9;
  localparam int GC_COUNT = 4;
  localparam int ADDR_W = 4;

  // ---------------------------------------------------------------
  // Divided clock relation
  // ---------------------------------------------------------------
  localparam int REF_FREQ_MHZ = 1000;
  localparam int TX_SER_WIDTH = 8;
  localparam int DIV_FREQ_MHZ = REF_FREQ_MHZ / TX_SER_WIDTH;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Control fields
  localparam int CTRL_SDR_STAGE = 0;
  localparam int CTRL_DDR_STAGE = 1;
  localparam int CTRL_RDY_STAGE = 2;
  localparam int CTRL_DATA_STAGE = 3;
  localparam int CTRL_PHY_STAGE = 4;

  // Status fields
  localparam int STAT_CONFLICT = 0;
  localparam int STAT_CORNER = 1;
  localparam int STAT_DELAY_READY_FLAG = 2;
  localparam int STAT_PHY_READY_FLAG = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : io_boundary_pkg

// File: hdl/boundary_ff.sv
`timescale 1ns/1ns
module boundary_ff #(
  parameter int W = 1,
  parameter bit HAS_CLEAR = 1'b1
) (
  // Clocking
  input wire logic clk,
  input wire logic en,
  input wire logic clr,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] q;
  } ff_state_t;

  ff_state_t s_r;
  ff_state_t s_nxt;

  // Load only while enabled, otherwise hold
  always_comb
  begin
    s_nxt = s_r;
    if (en)
    begin
      s_nxt.q = d;
    end
  end

  // No power-up value: stays unknown until first load or clear
  // no initial value
  generate
    if (HAS_CLEAR)
    begin : g_clr
      always_ff @(posedge clk or posedge clr)
      begin
        if (clr)
          s_r <= '0;
        else
          s_r <= s_nxt;
      end
    end
    else
    begin : g_plain
      // Plain variant: no reset input at all
      always_ff @(posedge clk)
      begin
        s_r <= s_nxt;
      end
    end
  endgenerate

  assign q = s_r.q;

endmodule : boundary_ff

// File: hdl/io_boundary_register_stage.sv
// Operation
// - A stage loads its input on the clock only while its enable is high.
// - The clearing stage variant drops its output low at once on clear.
// - Stages have no power-up value; output unknown until load or clear.
// - SDR and DDR I/O paths each pick the stage or a bypass.
// - Only the listed PHY control, data, flag and tap ports get stages.
// - Receive lanes use the FIFO read clock and their own receive reset.
// - Transmit lanes use the divided clock and their own transmit reset.
// - Four global clock inputs, single-ended or positive side of a pair.
// - Corner banks keep clock pins; other pins serve only memory control.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module io_boundary_register_stage #(
  parameter int LANES = io_boundary_pkg::LANES,
  parameter int LANE_W = io_boundary_pkg::LANE_W,
  parameter int TAP_W = io_boundary_pkg::TAP_W,
  parameter bit CORNER_BANK = 1'b0
) (
  // System clock, reset and freeze
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // PHY clocks and stage clears (active high)
  input wire logic ctrl_clk,
  input wire logic div_clk,
  input wire logic fifo_rd_clk,
  input wire logic phy_rst,
  input wire logic [LANES-1:0] rx_lane_rst,
  input wire logic [LANES-1:0] tx_lane_rst,
  // AXI4-Lite write
  input wire logic [io_boundary_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [io_boundary_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Global clock pins
  input wire logic [io_boundary_pkg::GC_COUNT-1:0] global_clock_input,
  output logic [io_boundary_pkg::GC_COUNT-1:0] gc_to_clock_mgr,
  output logic [io_boundary_pkg::GC_COUNT-1:0] gc_to_global_buf,
  // Simple I/O paths, fabric side
  input wire logic fab_sdr_out,
  output logic fab_sdr_in,
  input wire logic [1:0] fab_ddr_out,
  output logic [1:0] fab_ddr_in,
  // Simple I/O paths, I/O side
  output logic iol_sdr_out,
  input wire logic iol_sdr_in,
  output logic [1:0] iol_ddr_out,
  input wire logic [1:0] iol_ddr_in,
  // Memory controller pin drive for corner banks
  input wire logic mc_sdr_out,
  input wire logic [1:0] mc_ddr_out,
  // PHY control from fabric
  input wire logic fab_phy_ce,
  input wire logic fab_phy_read_enable,
  input wire logic fab_phy_write_enable,
  input wire logic fab_phy_write_select_a,
  input wire logic fab_phy_write_select_b,
  input wire logic fab_tap_ce,
  input wire logic fab_tap_inc,
  input wire logic fab_tap_load,
  input wire logic [TAP_W-1:0] fab_tap_value_in,
  input wire logic [LANES*LANE_W-1:0] fab_tx_data,
  // PHY control toward the nibble
  output logic phy_ce,
  output logic phy_read_enable,
  output logic phy_write_enable,
  output logic phy_write_select_a,
  output logic phy_write_select_b,
  output logic phy_tap_ce,
  output logic phy_tap_inc,
  output logic phy_tap_load,
  output logic [TAP_W-1:0] phy_tap_value_in,
  output logic [LANES*LANE_W-1:0] phy_tx_data,
  // PHY results from the nibble
  input wire logic [TAP_W-1:0] nib_tap_value_out,
  input wire logic nib_gate_training_status,
  input wire logic nib_delay_ready_flag,
  input wire logic nib_phy_ready_flag,
  input wire logic nib_fifo_empty,
  input wire logic [LANES*LANE_W-1:0] nib_rx_data,
  // PHY results toward fabric
  output logic [TAP_W-1:0] tap_value_out,
  output logic gate_training_status,
  output logic delay_ready_flag,
  output logic phy_ready_flag,
  output logic fifo_empty,
  output logic [LANES*LANE_W-1:0] rx_data
);

  // ---------------------------------------------------------------
  // Register file state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic aw_got;
    logic [io_boundary_pkg::ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [1:0] rdy_meta;
    logic [1:0] rdy_sync;
  } regs_state_t;

  localparam regs_state_t REGS_RESET = '{
    ctrl: io_boundary_pkg::CTRL_RESET,
    aw_addr: '0,
    wdata: '0,
    bresp: io_boundary_pkg::RESP_OKAY,
    rresp: io_boundary_pkg::RESP_OKAY,
    rdata: '0,
    rdy_meta: '0,
    rdy_sync: '0,
    default: 1'b0
  };

  regs_state_t s_r;
  regs_state_t s_nxt;
  logic sel_sdr, sel_ddr, sel_rdy, sel_data, sel_phy, conflict;
  logic [31:0] status_word;

  // Decoded stage selects; treated as quasi-static by the PHY domains
  assign sel_sdr = s_r.ctrl[io_boundary_pkg::CTRL_SDR_STAGE];
  assign sel_ddr = s_r.ctrl[io_boundary_pkg::CTRL_DDR_STAGE];
  assign sel_rdy = s_r.ctrl[io_boundary_pkg::CTRL_RDY_STAGE];
  assign sel_phy = s_r.ctrl[io_boundary_pkg::CTRL_PHY_STAGE];
  assign conflict = sel_rdy & s_r.ctrl[io_boundary_pkg::CTRL_DATA_STAGE];
  assign sel_data = s_r.ctrl[io_boundary_pkg::CTRL_DATA_STAGE] & ~sel_rdy;

  // Status view: conflict, corner flag, synchronised ready levels
  always_comb
  begin
    status_word = '0;
    status_word[io_boundary_pkg::STAT_CONFLICT] = conflict;
    status_word[io_boundary_pkg::STAT_CORNER] = CORNER_BANK;
    status_word[io_boundary_pkg::STAT_DELAY_READY_FLAG] = s_r.rdy_sync[0];
    status_word[io_boundary_pkg::STAT_PHY_READY_FLAG] = s_r.rdy_sync[1];
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  // Readies drop while frozen, so no handshake is lost with ce low
  assign s_axi_awready = ~s_r.aw_got & ~s_r.bvalid & ce;
  assign s_axi_wready = ~s_r.w_got & ~s_r.bvalid & ce;
  assign s_axi_arready = ~s_r.rvalid & ce;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rdata = s_r.rdata;

  // Address and data taken in either order, answer after both
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdy_meta = {nib_phy_ready_flag, nib_delay_ready_flag};
    s_nxt.rdy_sync = s_r.rdy_meta;
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata[7:0];
      s_nxt.wstrb0 = s_axi_wstrb[0];
    end
    if (s_r.aw_got && s_r.w_got)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = io_boundary_pkg::RESP_OKAY;
      if (s_r.aw_addr == io_boundary_pkg::CTRL_OFS)
      begin
        if (s_r.wstrb0)
          s_nxt.ctrl = s_r.wdata;
      end
      else if (s_r.aw_addr != io_boundary_pkg::STATUS_OFS)
        s_nxt.bresp = io_boundary_pkg::RESP_SLVERR;
    end
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;
    if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = io_boundary_pkg::RESP_OKAY;
      s_nxt.rdata = '0;
      case (s_axi_araddr)
        io_boundary_pkg::CTRL_OFS: s_nxt.rdata = {24'h000000, s_r.ctrl};
        io_boundary_pkg::STATUS_OFS: s_nxt.rdata = status_word;
        default: s_nxt.rresp = io_boundary_pkg::RESP_SLVERR;
      endcase
    end
  end

  // Freeze on ce low; reset is synchronous
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      s_r <= REGS_RESET;
    else if (ce)
      s_r <= s_nxt;
  end

  // ---------------------------------------------------------------
  // Global clock pins
  // ---------------------------------------------------------------
  // four clock pins
  assign gc_to_clock_mgr = global_clock_input;
  assign gc_to_global_buf = global_clock_input;

  // ---------------------------------------------------------------
  // Simple I/O stages (plain variant, no reset)
  // ---------------------------------------------------------------
  logic sdr_out_q, sdr_in_q;
  logic [1:0] ddr_out_q, ddr_in_q;

  boundary_ff #(.W(1), .HAS_CLEAR(1'b0)) u_sdr_out (
    .clk(clock), .en(ce), .clr(1'b0), .d(fab_sdr_out), .q(sdr_out_q));
  boundary_ff #(.W(1), .HAS_CLEAR(1'b0)) u_sdr_in (
    .clk(clock), .en(ce), .clr(1'b0), .d(iol_sdr_in), .q(sdr_in_q));
  boundary_ff #(.W(2), .HAS_CLEAR(1'b0)) u_ddr_out (
    .clk(clock), .en(ce), .clr(1'b0), .d(fab_ddr_out), .q(ddr_out_q));
  boundary_ff #(.W(2), .HAS_CLEAR(1'b0)) u_ddr_in (
    .clk(clock), .en(ce), .clr(1'b0), .d(iol_ddr_in), .q(ddr_in_q));

  assign iol_sdr_out = CORNER_BANK ? mc_sdr_out : (sel_sdr ? sdr_out_q : fab_sdr_out);
  assign iol_ddr_out = CORNER_BANK ? mc_ddr_out : (sel_ddr ? ddr_out_q : fab_ddr_out);
  assign fab_sdr_in = CORNER_BANK ? 1'b0 : (sel_sdr ? sdr_in_q : iol_sdr_in);
  assign fab_ddr_in = CORNER_BANK ? 2'b00 : (sel_ddr ? ddr_in_q : iol_ddr_in);

  // ---------------------------------------------------------------
  // PHY stages, control clock domain
  // ---------------------------------------------------------------
  logic phy_ce_q;
  logic [TAP_W+2:0] tap_ctl_q;
  logic [TAP_W:0] tap_res_q;
  logic [1:0] rdy_q;

  boundary_ff #(.W(1), .HAS_CLEAR(1'b0)) u_phy_ce (
    .clk(ctrl_clk), .en(ce), .clr(1'b0), .d(fab_phy_ce), .q(phy_ce_q));
  boundary_ff #(.W(TAP_W + 3), .HAS_CLEAR(1'b1)) u_tap_ctl (
    .clk(ctrl_clk), .en(ce), .clr(phy_rst),
    .d({fab_tap_ce, fab_tap_inc, fab_tap_load, fab_tap_value_in}), .q(tap_ctl_q));
  boundary_ff #(.W(TAP_W + 1), .HAS_CLEAR(1'b1)) u_tap_res (
    .clk(ctrl_clk), .en(ce), .clr(phy_rst),
    .d({nib_tap_value_out, nib_gate_training_status}), .q(tap_res_q));
  boundary_ff #(.W(2), .HAS_CLEAR(1'b1)) u_rdy (
    .clk(ctrl_clk), .en(ce), .clr(phy_rst),
    .d({nib_phy_ready_flag, nib_delay_ready_flag}), .q(rdy_q));

  assign phy_ce = sel_phy ? phy_ce_q : fab_phy_ce;
  assign {phy_tap_ce, phy_tap_inc, phy_tap_load, phy_tap_value_in} = sel_phy ? tap_ctl_q :
    {fab_tap_ce, fab_tap_inc, fab_tap_load, fab_tap_value_in};
  assign {tap_value_out, gate_training_status} = sel_phy ? tap_res_q :
    {nib_tap_value_out, nib_gate_training_status};
  assign {phy_ready_flag, delay_ready_flag} = sel_rdy ? rdy_q :
    {nib_phy_ready_flag, nib_delay_ready_flag};

  // ---------------------------------------------------------------
  // PHY stages, divided and FIFO read clock domains
  // ---------------------------------------------------------------
  logic [3:0] div_ctl_q;
  logic empty_q;
  logic [LANES*LANE_W-1:0] tx_q, rx_q;

  // Divided clock is reference over serialisation width
  // divided domain
  boundary_ff #(.W(4), .HAS_CLEAR(1'b1)) u_div_ctl (
    .clk(div_clk), .en(ce), .clr(phy_rst),
    .d({fab_phy_read_enable, fab_phy_write_enable, fab_phy_write_select_a,
        fab_phy_write_select_b}),
    .q(div_ctl_q));
  boundary_ff #(.W(1), .HAS_CLEAR(1'b1)) u_empty (
    .clk(fifo_rd_clk), .en(ce), .clr(phy_rst), .d(nib_fifo_empty), .q(empty_q));

  // One stage per lane so each lane keeps its own clear
  generate
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
      boundary_ff #(.W(LANE_W), .HAS_CLEAR(1'b1)) u_tx (
        .clk(div_clk), .en(ce), .clr(tx_lane_rst[i]),
        .d(fab_tx_data[i*LANE_W +: LANE_W]), .q(tx_q[i*LANE_W +: LANE_W]));
      boundary_ff #(.W(LANE_W), .HAS_CLEAR(1'b1)) u_rx (
        .clk(fifo_rd_clk), .en(ce), .clr(rx_lane_rst[i]),
        .d(nib_rx_data[i*LANE_W +: LANE_W]), .q(rx_q[i*LANE_W +: LANE_W]));
    end
  endgenerate

  assign {phy_read_enable, phy_write_enable, phy_write_select_a, phy_write_select_b} =
    sel_phy ? div_ctl_q :
    {fab_phy_read_enable, fab_phy_write_enable, fab_phy_write_select_a,
     fab_phy_write_select_b};
  assign fifo_empty = sel_phy ? empty_q : nib_fifo_empty;
  assign phy_tx_data = sel_phy ? tx_q : fab_tx_data;
  assign rx_data = sel_data ? rx_q : nib_rx_data;

endmodule : io_boundary_register_stage

// File: dv/fabric_model.sv
`timescale 1ns/1ns
// Fabric stand-in: one counter drives every fabric-side output
module fabric_model #(
  parameter int DW = 48,
  parameter int TW = 9
) (
  // Clock and freeze
  input wire logic clock,
  input wire logic hold,
  // Fabric drive
  output logic sdr_out,
  output logic [1:0] ddr_out,
  output logic [7:0] phy_ctl,
  output logic [TW-1:0] tap_in,
  output logic [DW-1:0] tx_data
);
  logic [7:0] cnt_r = 8'h00;
  // sync reset tied off: no reset is driven, so plain stages never see one
  // Holding lets slow PHY domains settle before a compare
  always @(posedge clock)
    if (!hold)
      cnt_r <= cnt_r + 8'h01;
  assign sdr_out = cnt_r[0];
  assign ddr_out = cnt_r[2:1];
  assign phy_ctl = cnt_r ^ 8'hA5;
  assign tap_in = {cnt_r[3], cnt_r};
  assign tx_data = {(DW / 8){cnt_r ^ 8'h3C}};
endmodule : fabric_model

// File: dv/io_boundary_monitor.sv
`timescale 1ns/1ns
module io_boundary_monitor #(
  parameter int LANES = 6,
  parameter int LANE_W = 8
) (
  // Clock, reset, freeze, clears
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [LANES-1:0] rx_lane_rst,
  // Bus write
  input wire logic [io_boundary_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Watched paths
  input wire logic [io_boundary_pkg::GC_COUNT-1:0] global_clock_input,
  input wire logic [io_boundary_pkg::GC_COUNT-1:0] gc_to_clock_mgr,
  input wire logic [io_boundary_pkg::GC_COUNT-1:0] gc_to_global_buf,
  input wire logic fab_sdr_out,
  input wire logic iol_sdr_out,
  input wire logic [1:0] fab_ddr_out,
  input wire logic [1:0] iol_ddr_out,
  input wire logic [LANES*LANE_W-1:0] nib_rx_data,
  input wire logic [LANES*LANE_W-1:0] rx_data
);
  // ---------------------------------------------------------------
  // Control shadow
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [8:0] wd_r;
  logic [3:0] ad_r;
  logic pend_r, aw_hs, w_hs, busy;
  assign aw_hs = s_axi_awvalid && s_axi_awready && ce;
  assign w_hs = s_axi_wvalid && s_axi_wready && ce;
  // Selects may move while a write is open, so checks pause then
  assign busy = pend_r || s_axi_bvalid || aw_hs || w_hs;
  // Shadow follows completed writes to the control word
  always_ff @(posedge clock)
    if (!rst_n)
    begin
      ctrl_r <= 8'h00;
      pend_r <= 1'b0;
    end
    else if (ce)
    begin
      if (aw_hs)
        ad_r <= s_axi_awaddr;
      if (w_hs)
        wd_r <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
      if (aw_hs || w_hs)
        pend_r <= 1'b1;
      if (s_axi_bvalid && s_axi_bready)
      begin
        pend_r <= 1'b0;
        if (ad_r == io_boundary_pkg::CTRL_OFS && wd_r[8])
          ctrl_r <= wd_r[7:0];
      end
    end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence sdr_staged;
    !busy && ctrl_r[0];
  endsequence
  sequence rx_staged_clear;
    !busy && ctrl_r[3] && !ctrl_r[2] && rx_lane_rst[0];
  endsequence
  a_gc_mgr_pass: assert property (gc_to_clock_mgr == global_clock_input)
    else $error("clock pin lost on way to clock manager");
  a_gc_buf_pass: assert property (gc_to_global_buf == global_clock_input)
    else $error("clock pin lost on way to global buffer");
  a_sdr_bypass: assert property (!busy && !ctrl_r[0] |-> iol_sdr_out == fab_sdr_out)
    else $error("single-rate bypass does not follow fabric");
  a_ddr_bypass: assert property (!busy && !ctrl_r[1] |-> iol_ddr_out == fab_ddr_out)
    else $error("double-rate bypass does not follow fabric");
  a_sdr_stage_load: assert property (sdr_staged ##0 ce |=> iol_sdr_out == $past(fab_sdr_out))
    else $error("single-rate stage missed its load");
  a_sdr_stage_hold: assert property (sdr_staged ##0 !ce |=> $stable(iol_sdr_out))
    else $error("single-rate stage moved with enable low");
  a_rx_clear_low: assert property (rx_staged_clear |-> rx_data[LANE_W-1:0] == '0)
    else $error("receive lane not low under its clear");
  a_rx_bypass: assert property (!busy && (!ctrl_r[3] || ctrl_r[2]) |-> rx_data == nib_rx_data)
    else $error("receive lanes not bypassed");
endmodule : io_boundary_monitor

bind io_boundary_register_stage io_boundary_monitor #(.LANES(LANES), .LANE_W(LANE_W)) i_mon (.*);

// File: dv/io_boundary_register_stage_tb.sv
`timescale 1ns/1ns
module io_boundary_register_stage_tb;
  localparam int DW = io_boundary_pkg::LANES * io_boundary_pkg::LANE_W;
  localparam int TW = io_boundary_pkg::TAP_W;
  localparam logic [1:0] OK = io_boundary_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = io_boundary_pkg::RESP_SLVERR;
  localparam logic [3:0] CTRL = io_boundary_pkg::CTRL_OFS;
  localparam logic [3:0] STAT = io_boundary_pkg::STATUS_OFS;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clock = 1'b0, ctrl_clk = 1'b0, div_clk = 1'b0, fifo_rd_clk = 1'b0;
  logic rst_n = 1'b0, ce = 1'b1, phy_rst = 1'b0, hold = 1'b0, mc_sdr_out = 1'b0;
  logic [5:0] rx_lane_rst = 6'h00, tx_lane_rst = 6'h00, got_s, exp_s, snap;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [3:0] global_clock_input = 4'h0, gc_to_clock_mgr, gc_to_global_buf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic nib_delay_ready_flag = 1'b1, nib_phy_ready_flag = 1'b0;
  logic [1:0] mc_ddr_out = 2'h0, s_axi_bresp, s_axi_rresp;
  logic [1:0] fab_ddr_out, fab_ddr_in, iol_ddr_out, iol_ddr_in;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic fab_sdr_out, fab_sdr_in, iol_sdr_out, iol_sdr_in, nib_fifo_empty;
  logic fab_phy_ce, fab_phy_read_enable, fab_phy_write_enable, fab_phy_write_select_a;
  logic fab_phy_write_select_b, fab_tap_ce, fab_tap_inc, fab_tap_load, fifo_empty;
  logic phy_ce, phy_read_enable, phy_write_enable, phy_write_select_a, phy_write_select_b;
  logic phy_tap_ce, phy_tap_inc, phy_tap_load, gate_training_status, delay_ready_flag;
  logic phy_ready_flag, nib_gate_training_status;
  logic [TW-1:0] fab_tap_value_in, phy_tap_value_in, nib_tap_value_out, tap_value_out;
  logic [DW-1:0] fab_tx_data, phy_tx_data, nib_rx_data, rx_data;
  logic [7:0] phy_ctl;
  logic [131:0] got_f, exp_f;
  int failures = 0, cmp_count = 0;
  // Bus clock at 10 MHz; PHY clocks on unrelated periods, divided one scaled down
  always #50 clock = ~clock;
  always #20 ctrl_clk = ~ctrl_clk;
  always #40 div_clk = ~div_clk;
  always #30 fifo_rd_clk = ~fifo_rd_clk;
  // ---------------------------------------------------------------
  // Fabric, echo of the far pins, design
  // ---------------------------------------------------------------
  fabric_model #(.DW(DW), .TW(TW)) i_fab (.clock(clock), .hold(hold), .sdr_out(fab_sdr_out),
    .ddr_out(fab_ddr_out), .phy_ctl(phy_ctl), .tap_in(fab_tap_value_in), .tx_data(fab_tx_data));
  assign {fab_tap_load, fab_tap_inc, fab_tap_ce, fab_phy_write_select_b} = phy_ctl[7:4];
  assign {fab_phy_write_select_a, fab_phy_write_enable, fab_phy_read_enable} = phy_ctl[3:1];
  assign fab_phy_ce = phy_ctl[0];
  // Inverted echo keeps the inward pin, tap and receive paths moving with the fabric; the two ready flags stay fixed
  assign iol_sdr_in = ~fab_sdr_out;
  assign iol_ddr_in = ~fab_ddr_out;
  assign nib_rx_data = ~fab_tx_data;
  assign nib_tap_value_out = ~fab_tap_value_in;
  assign nib_gate_training_status = phy_ctl[2];
  assign nib_fifo_empty = phy_ctl[5];
  assign got_s = {iol_sdr_out, iol_ddr_out, fab_sdr_in, fab_ddr_in};
  assign exp_s = {fab_sdr_out, fab_ddr_out, iol_sdr_in, iol_ddr_in};
  assign got_f = {phy_ce, phy_write_enable, phy_write_select_a, phy_write_select_b, phy_tap_ce,
    phy_tap_inc, phy_tap_value_in, gate_training_status, delay_ready_flag, phy_ready_flag,
    fifo_empty, phy_read_enable, phy_tap_load, tap_value_out, phy_tx_data, rx_data, got_s};
  assign exp_f = {fab_phy_ce, fab_phy_write_enable, fab_phy_write_select_a,
    fab_phy_write_select_b, fab_tap_ce, fab_tap_inc, fab_tap_value_in, nib_gate_training_status,
    nib_delay_ready_flag, nib_phy_ready_flag, nib_fifo_empty, fab_phy_read_enable,
    fab_tap_load, nib_tap_value_out, fab_tx_data, nib_rx_data, exp_s};
  io_boundary_register_stage i_dut (.*);
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [131:0] got, input logic [131:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Ready is looked at on the falling edge, stable up to the next rise
  task automatic axi_write(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s,
    input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge clock);
    {aw, w, b} = 3'b110;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 24'h0, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (aw || w || !b)
    begin
      @(negedge clock);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {aw, w, !b};
    end
    chk(r, er);
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic t, v;
    logic [33:0] rd;
    @(posedge clock);
    {t, v} = 2'b10;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    while (t || !v)
    begin
      @(negedge clock);
      t = t && !s_axi_arready;
      v = s_axi_rvalid;
      rd = {s_axi_rresp, s_axi_rdata};
      @(posedge clock);
      {s_axi_arvalid, s_axi_rready} <= {t, !v};
    end
    chk(rd, {er, ed});
  endtask : axi_read
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    axi_read(CTRL, 32'h0, OK);
    axi_read(STAT, 32'h1 << io_boundary_pkg::STAT_DELAY_READY_FLAG, OK);
    axi_read(4'h8, 32'h0, ERR);
    axi_write(4'hC, 8'h1F, 4'hF, ERR);
    axi_write(STAT, 8'hFF, 4'hF, OK);
    axi_write(CTRL, 8'hFF, 4'h0, OK);
    axi_read(CTRL, 32'h0, OK);
    global_clock_input <= 4'hA;
    @(negedge clock);
    chk(gc_to_clock_mgr, 4'hA);
    chk(gc_to_global_buf, 4'hA);
    chk(got_f, exp_f);
    hold <= 1'b1;
    axi_write(CTRL, 8'h1B, 4'hF, OK);
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk(got_f, exp_f);
    // One fabric step: staged paths lag by one edge
    snap = exp_s;
    @(posedge clock);
    hold <= 1'b0;
    @(posedge clock);
    hold <= 1'b1;
    @(negedge clock);
    chk(got_s, snap);
    // Enable low across a fabric step freezes the stages
    @(posedge clock);
    {ce, hold} <= 2'b00;
    snap = exp_s;
    @(posedge clock);
    hold <= 1'b1;
    @(negedge clock);
    chk(got_s, snap);
    @(posedge clock);
    ce <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(got_s, exp_s);
    // Lane clears act at once and only on their own lane
    @(posedge clock);
    {rx_lane_rst, tx_lane_rst, phy_rst} <= {6'h01, 6'h02, 1'b1};
    @(negedge clock);
    chk(rx_data[15:0], {nib_rx_data[15:8], 8'h00});
    chk(phy_tx_data[15:0], {8'h00, fab_tx_data[7:0]});
    chk({phy_read_enable, fifo_empty, phy_tap_load, tap_value_out}, 12'h000);
    @(posedge clock);
    {rx_lane_rst, tx_lane_rst, phy_rst} <= 13'h0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk(got_f, exp_f);
    // Flags and receive lanes both asked for staging
    axi_write(CTRL, 8'h0C, 4'h1, OK);
    axi_read(STAT, 32'h5, OK);
    hold <= 1'b0;
    repeat (2) @(negedge clock);
    chk(rx_data, nib_rx_data);
    stop_test();
  end
  // Watchdog well beyond the few dozen bus cycles the tests need
  initial
  begin
    #100000;
    failures++;
    stop_test();
  end
endmodule : io_boundary_register_stage_tb
